// [hw/lpmc_regs.svh]
// Register map, field positions, reset values and timing counts of the
// low-power mode controller. Assumes a 32-bit physical address bus.
`ifndef LPMC_REGS_SVH
`define LPMC_REGS_SVH
// ----------------------------------------
// Addresses and reset values
// ----------------------------------------
`define LPMC_ADDR_PMC 32'h10000004
`define LPMC_ADDR_GATE 32'h10000020
`define LPMC_ADDR_SOPT 32'h10000024
`define LPMC_RST_PMC 8'hF8
`define LPMC_RST_GATE 16'h0000
`define LPMC_RST_SOPT 32'h00001500
// ----------------------------------------
// Fields and counts
// ----------------------------------------
`define LPMC_DOZE_BIT 2
`define LPMC_DUTY_HI 7
`define LPMC_DUTY_LO 3
`define LPMC_MODE_HI 1
`define LPMC_MODE_LO 0
`define LPMC_MODE_IDLE 2'h0
`define LPMC_MODE_SLEEP 2'h1
`define LPMC_DUTY_FULL 5'h1F
`define LPMC_DUTY_OFF 5'h00
`define LPMC_WIN_LAST 5'h1E
`define LPMC_PMC_HI 7
`define LPMC_GATE_HI 15
`endif

// [hw/lpmc_pkg.sv]
// Types shared by the low-power mode controller.
// Assumes the constants header is included where numbers are needed.
package lpmc_pkg;
	// Controller power states
	typedef enum logic [2:0]
	{
		LPMC_RUN = 3'b000,
		LPMC_IDLE = 3'b001,
		LPMC_SLEEP = 3'b010,
		LPMC_LOCK = 3'b011
	} lpmc_state_e;
	// Register access request from the CPU
	typedef struct packed
	{
		logic sel;
		logic wr;
		logic size32;
		logic [31:0] addr;
		logic [31:0] wdata;
	} lpmc_req_s;
	// Clock enables driven to the clock tree
	typedef struct packed
	{
		logic cpu;
		logic basic;
		logic pll;
		logic [15:0] module_en;
	} lpmc_clk_s;
endpackage

// [hw/lpmc_top.sv]
// Low-power mode controller: doze bursts, idle, sleep with PLL lock wait,
// and per-module clock gating. Assumes clk is an always-on clock that
// keeps running in sleep, and that the clock tree obeys the enables.
`timescale 1ns/100ps
`include "lpmc_regs.svh"
module lpmc_top
	import lpmc_pkg::*;
(
	input wire logic clk, // 10 MHz always-on clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire lpmc_req_s req, // Register request
	output logic [31:0] rdata, // Read data, one cycle after
	output logic rvalid, // Read data valid pulse
	input wire logic sleep_instr, // CPU executed sleep, pulse
	input wire logic irq_active, // Any interrupt pending, level
	input wire logic rtc_clk_in, // RTC clock, foreign domain
	input wire logic [7:0] pll_lock_time, // Lock wait in RTC cycles
	output lpmc_clk_s clk_en, // Clock enables
	output lpmc_state_e pm_state // Current power state
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] power_manager; // Control register low byte
	logic [15:0] gate; // Module gate bits
	logic [31:0] sopt; // Sleep options, stored only
	logic [4:0] win_cnt; // Doze window position
	logic [7:0] lock_cnt; // Remaining lock ticks
	logic rtc_ff1; // Sync stage one
	logic rtc_ff2; // Sync stage two
	logic rtc_ff3; // Sync stage three
	logic rtc_lvl; // Filtered RTC level
	logic rtc_tick; // RTC rising edge
	logic wr_pmc; // Valid write to control
	logic wr_gate; // Valid write to gates
	logic wr_sopt; // Valid write to options
	logic doze; // Doze bit
	logic [4:0] duty; // Duty field
	logic [1:0] mode_sel; // Sleep instruction mode
	lpmc_state_e next_state; // Next power state

	// Decode a 32-bit write to one address
	function automatic logic hit(input lpmc_req_s r, input logic [31:0] a);
		hit = r.sel && r.wr && r.size32 && (r.addr == a);
	endfunction

	assign doze = power_manager[`LPMC_DOZE_BIT];
	assign duty = power_manager[`LPMC_DUTY_HI:`LPMC_DUTY_LO];
	assign mode_sel = power_manager[`LPMC_MODE_HI:`LPMC_MODE_LO];
	// Narrow accesses are dropped, not merged
	assign wr_pmc = hit(req, `LPMC_ADDR_PMC);
	assign wr_gate = hit(req, `LPMC_ADDR_GATE);
	assign wr_sopt = hit(req, `LPMC_ADDR_SOPT);

	// ----------------------------------------
	// RTC synchroniser
	// ----------------------------------------
	// Three stages; level taken only when the last two agree
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rtc_ff1 <= 1'b0;
			rtc_ff2 <= 1'b0;
			rtc_ff3 <= 1'b0;
			rtc_lvl <= 1'b0;
		end
		else
		begin
			rtc_ff1 <= rtc_clk_in;
			rtc_ff2 <= rtc_ff1;
			rtc_ff3 <= rtc_ff2;
			if (rtc_ff2 == rtc_ff3)
			begin
				rtc_lvl <= rtc_ff3;
			end
		end
	end
	assign rtc_tick = (rtc_ff2 == rtc_ff3) && rtc_ff3 && !rtc_lvl;

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	// Interrupt cancels doze even against a same-cycle write of one,
	// since a pending interrupt would end it at once anyway
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			power_manager <= `LPMC_RST_PMC;
		end
		else if (doze && irq_active)
		begin
			power_manager[`LPMC_DOZE_BIT] <= 1'b0;
			if (wr_pmc)
			begin
				power_manager[`LPMC_DUTY_HI:`LPMC_DUTY_LO] <= req.wdata[`LPMC_DUTY_HI:`LPMC_DUTY_LO];
				power_manager[`LPMC_MODE_HI:`LPMC_MODE_LO] <= req.wdata[`LPMC_MODE_HI:`LPMC_MODE_LO];
			end
		end
		else if (wr_pmc)
		begin
			// Bit 2 written 1 enters doze unless an interrupt is pending, 0 leaves it
			power_manager <= req.wdata[`LPMC_PMC_HI:0];
			if (irq_active)
			begin
				power_manager[`LPMC_DOZE_BIT] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Gate and option registers
	// ----------------------------------------
	// Gate bits hold until software clears them or reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			gate <= `LPMC_RST_GATE;
			sopt <= `LPMC_RST_SOPT;
		end
		else
		begin
			if (wr_gate)
			begin
				gate <= req.wdata[`LPMC_GATE_HI:0];
			end
			if (wr_sopt)
			begin
				sopt <= req.wdata;
			end
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Unmapped or narrow reads return zero
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rdata <= 32'h00000000;
			rvalid <= 1'b0;
		end
		else
		begin
			rvalid <= req.sel && !req.wr;
			rdata <= 32'h00000000;
			if (req.sel && !req.wr && req.size32)
			begin
				case (req.addr)
					`LPMC_ADDR_PMC: rdata <= {24'h000000, power_manager};
					`LPMC_ADDR_GATE: rdata <= {16'h0000, gate};
					`LPMC_ADDR_SOPT: rdata <= sopt;
					default: rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Doze window counter
	// ----------------------------------------
	// Free count 0..30 while dozing; restarts at 0 on each entry
	always_ff @(posedge clk)
	begin
		if (sys_rst || !doze)
		begin
			win_cnt <= 5'h00;
		end
		else if (win_cnt == `LPMC_WIN_LAST)
		begin
			win_cnt <= 5'h00;
		end
		else
		begin
			win_cnt <= win_cnt + 5'h01;
		end
	end

	// ----------------------------------------
	// Power state machine
	// ----------------------------------------
	// Reserved mode codes make the sleep instruction a no-op
	always_comb
	begin
		next_state = pm_state;
		case (pm_state)
			LPMC_RUN:
			begin
				if (sleep_instr && !irq_active)
				begin
					if (mode_sel == `LPMC_MODE_IDLE)
					begin
						next_state = LPMC_IDLE;
					end
					else if (mode_sel == `LPMC_MODE_SLEEP)
					begin
						next_state = LPMC_SLEEP;
					end
				end
			end
			LPMC_IDLE:
			begin
				if (irq_active)
				begin
					next_state = LPMC_RUN;
				end
			end
			LPMC_SLEEP:
			begin
				if (irq_active)
				begin
					next_state = LPMC_LOCK;
				end
			end
			LPMC_LOCK:
			begin
				if (lock_cnt == 8'h00)
				begin
					next_state = LPMC_RUN;
				end
			end
			default: next_state = LPMC_RUN;
		endcase
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pm_state <= LPMC_RUN;
		end
		else
		begin
			pm_state <= next_state;
		end
	end

	// Lock counter loads on wake, counts RTC edges down
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			lock_cnt <= 8'h00;
		end
		else if (pm_state == LPMC_SLEEP)
		begin
			lock_cnt <= pll_lock_time;
		end
		else if (pm_state == LPMC_LOCK && rtc_tick && lock_cnt != 8'h00)
		begin
			lock_cnt <= lock_cnt - 8'h01;
		end
	end

	// ----------------------------------------
	// Clock enables
	// ----------------------------------------
	// Derived from flops only; doze exit shows on the same edge as the
	// doze bit clearing, so the continuous clock is back at once
	always_comb
	begin
		clk_en.basic = (pm_state == LPMC_RUN) || (pm_state == LPMC_IDLE);
		clk_en.pll = (pm_state != LPMC_SLEEP);
		clk_en.module_en = ((pm_state == LPMC_RUN) || (pm_state == LPMC_IDLE)) ? ~gate : 16'h0000;
		clk_en.cpu = (pm_state == LPMC_RUN) && (!doze || (win_cnt < duty));
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_doze_enter;
		wr_pmc && req.wdata[`LPMC_DOZE_BIT] && !irq_active |=> doze;
	endproperty
	a_doze_enter: assert property (p_doze_enter) else $error("doze not entered");

	property p_doze_irq_cancel;
		doze && irq_active |=> !doze && (pm_state != LPMC_RUN || clk_en.cpu);
	endproperty
	a_doze_irq_cancel: assert property (p_doze_irq_cancel) else $error("doze kept");

	property p_duty_off;
		doze && duty == `LPMC_DUTY_OFF |-> !clk_en.cpu;
	endproperty
	a_duty_off: assert property (p_duty_off) else $error("cpu clock with zero duty");

	property p_duty_full;
		pm_state == LPMC_RUN && duty == `LPMC_DUTY_FULL |-> clk_en.cpu;
	endproperty
	a_duty_full: assert property (p_duty_full) else $error("full duty gap");

	property p_window_wrap;
		doze && win_cnt == `LPMC_WIN_LAST && !$past(sys_rst) |=> !doze || win_cnt == 5'h00;
	endproperty
	a_window_wrap: assert property (p_window_wrap) else $error("window not 31");

	property p_idle_clocks;
		pm_state == LPMC_IDLE |-> !clk_en.cpu && clk_en.basic && clk_en.pll;
	endproperty
	a_idle_clocks: assert property (p_idle_clocks) else $error("idle clocks wrong");

	property p_idle_exit;
		pm_state == LPMC_IDLE && irq_active |=> pm_state == LPMC_RUN;
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("idle not left");

	property p_sleep_off;
		pm_state == LPMC_SLEEP |-> !clk_en.pll && !clk_en.cpu && clk_en.module_en == 16'h0000;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("sleep clocks on");

	property p_sleep_wake;
		pm_state == LPMC_SLEEP && irq_active |=> pm_state == LPMC_LOCK && clk_en.pll;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not left");

	property p_lock_hold;
		pm_state == LPMC_LOCK && lock_cnt != 8'h00 |=> pm_state == LPMC_LOCK;
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lock wait cut short");

	property p_sleep_select;
		pm_state == LPMC_RUN && sleep_instr && !irq_active && mode_sel == `LPMC_MODE_SLEEP
			|=> pm_state == LPMC_SLEEP;
	endproperty
	a_sleep_select: assert property (p_sleep_select) else $error("sleep mode missed");

	property p_gate_run;
		pm_state == LPMC_RUN |-> clk_en.module_en == ~gate && clk_en.basic;
	endproperty
	a_gate_run: assert property (p_gate_run) else $error("gating wrong in run");

	property p_pmc_upper_zero;
		$past(req.sel && !req.wr && req.size32 && req.addr == `LPMC_ADDR_PMC)
			|-> rdata[31:8] == 24'h000000;
	endproperty
	a_pmc_upper_zero: assert property (p_pmc_upper_zero) else $error("upper bits set");

	property p_narrow_ignored;
		req.sel && req.wr && !req.size32 && !(doze && irq_active) |=> $stable(power_manager) && $stable(gate);
	endproperty
	a_narrow_ignored: assert property (p_narrow_ignored) else $error("narrow write taken");

	property p_reset_value;
		@(posedge clk) disable iff (1'b0) sys_rst |=> power_manager == `LPMC_RST_PMC && pm_state == LPMC_RUN;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("bad reset value");

	c_doze_burst: cover property (doze && clk_en.cpu ##1 doze && !clk_en.cpu);
	c_idle_trip: cover property (pm_state == LPMC_IDLE ##1 pm_state == LPMC_RUN);
	c_sleep_trip: cover property (pm_state == LPMC_LOCK ##1 pm_state == LPMC_RUN);
	c_gate_set: cover property (wr_gate && req.wdata[15:0] != 16'h0000);
endmodule // lpmc_top

// [sim/lpmc_rtc_model.sv]
// Free-running real-time clock source for the mode controller bench.
// Assumes the controller synchronises this clock into its own domain.
`timescale 1ns/100ps
module lpmc_rtc_model
#(
	parameter int HALF_NS = 350 // Half period, not tied to clk
)
(
	output logic rtc_clk // Slow always-on clock
);
	// Odd start offset keeps its phase apart from the system clock
	initial
	begin
		rtc_clk = 1'b0;
		#137;
		forever #HALF_NS rtc_clk = ~rtc_clk;
	end
endmodule // lpmc_rtc_model

// [sim/lpmc_top_tb.sv]
// Self-checking bench for the low-power mode controller.
// Assumes the register, state and clock-enable ports of lpmc_top.
`timescale 1ns/100ps
`include "lpmc_regs.svh"
module lpmc_top_tb;
	import lpmc_pkg::*;
	logic clk; // 100 ns system clock
	logic sys_rst; // Synchronous reset
	lpmc_req_s req; // Register request
	logic [31:0] rdata; // Read data
	logic rvalid; // Read data valid
	logic sleep_instr; // Sleep instruction pulse
	logic irq_active; // Interrupt level
	logic rtc_clk; // From the partner model
	logic [7:0] pll_lock_time; // Lock wait count
	lpmc_clk_s clk_en; // Clock enables
	lpmc_state_e pm_state; // Power state
	int fail_count; // Mismatches seen
	int tests_run; // Comparisons made
	logic [31:0] exp_q [$]; // Expected read data, oldest first
	logic [31:0] seed; // Xorshift state
	logic [4:0] duty [3]; // Duty values tried in doze
	logic [15:0] g; // Random gate pattern
	int n; // CPU enable count or wait count
	// ----------------------------------------
	// Design, partner and clock
	// ----------------------------------------
	lpmc_top u_lpmc_top (.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
		.rvalid(rvalid), .sleep_instr(sleep_instr), .irq_active(irq_active),
		.rtc_clk_in(rtc_clk), .pll_lock_time(pll_lock_time), .clk_en(clk_en),
		.pm_state(pm_state));
	lpmc_rtc_model u_lpmc_rtc_model (.rtc_clk(rtc_clk));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic step;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Request held one edge, then a quiet cycle so the strobe never toggles twice
	task automatic bus(input logic w, input logic sz, input logic [31:0] a, input logic [31:0] d);
		req = '{1'b1, w, sz, a, d};
		step;
		req.sel = 1'b0;
		step;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 32'h00000000);
	endtask
	// One-cycle sleep instruction pulse
	task automatic slp;
		sleep_instr = 1'b1;
		step;
		sleep_instr = 1'b0;
	endtask
	task automatic print_verdict;
		if (fail_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Read monitor: every read answer takes the oldest expectation
	always @(posedge clk)
	begin
		if (rvalid === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk("unexpected_read", 32'h00000000, 32'h00000001);
			else
				chk("rdata", exp_q.pop_front(), rdata);
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		sys_rst = 1'b1;
		req = '0;
		sleep_instr = 1'b0;
		irq_active = 1'b0;
		seed = 32'h00005C72;
		pll_lock_time = 8'h03;
		repeat (5) step;
		sys_rst = 1'b0;
		rd(`LPMC_ADDR_PMC, 32'h000000F8);
		rd(`LPMC_ADDR_GATE, 32'h00000000);
		rd(`LPMC_ADDR_SOPT, `LPMC_RST_SOPT);
		rd(32'h10000008, 32'h00000000);
		// Doze bursts at three duties, random one in the middle
		seed = xs(seed);
		duty = '{`LPMC_DUTY_OFF, 5'(seed % 30 + 1), `LPMC_DUTY_FULL};
		for (int i = 0; i < 3; i++)
		begin
			seed = xs(seed);
			bus(1'b1, 1'b1, `LPMC_ADDR_PMC, {seed[31:8], duty[i], 3'h4});
			rd(`LPMC_ADDR_PMC, {24'h0, duty[i], 3'h4});
			n = 0;
			for (int c = 0; c < 31; c++)
			begin
				n += (clk_en.cpu === 1'b1);
				chk("basic_doze", 1, clk_en.basic);
				step;
			end
			chk("doze_burst", 32'(duty[i]), n);
			bus(1'b1, 1'b1, `LPMC_ADDR_PMC, {24'h0, duty[i], 3'h0});
			chk("cpu_after_clear", 1, clk_en.cpu);
		end
		// Interrupt ends doze and clears the bit by itself
		bus(1'b1, 1'b1, `LPMC_ADDR_PMC, 32'h00000014);
		irq_active = 1'b1;
		step;
		irq_active = 1'b0;
		chk("cpu_after_irq", 1, clk_en.cpu);
		rd(`LPMC_ADDR_PMC, 32'h00000010);
		// Random gating, narrow write refused, then ungate
		seed = xs(seed);
		g = seed[15:0];
		bus(1'b1, 1'b1, `LPMC_ADDR_GATE, seed);
		chk("module_en", {16'h0000, ~g}, {16'h0000, clk_en.module_en});
		chk("basic_gated", 1, clk_en.basic);
		bus(1'b1, 1'b0, `LPMC_ADDR_GATE, 32'h0000FFFF);
		rd(`LPMC_ADDR_GATE, {16'h0, g});
		bus(1'b1, 1'b1, `LPMC_ADDR_GATE, 32'h00000000);
		chk("ungated", 32'h0000FFFF, 32'(clk_en.module_en));
		// Reserved mode select is ignored
		bus(1'b1, 1'b1, `LPMC_ADDR_PMC, 32'h000000FA);
		slp;
		chk("reserved_mode", 32'(LPMC_RUN), 32'(pm_state));
		// Idle entry and interrupt exit
		bus(1'b1, 1'b1, `LPMC_ADDR_PMC, 32'h000000F8);
		slp;
		chk("idle_state", 32'(LPMC_IDLE), 32'(pm_state));
		chk("idle_cpu", 0, clk_en.cpu);
		chk("idle_basic", 1, clk_en.basic);
		irq_active = 1'b1;
		step;
		irq_active = 1'b0;
		chk("idle_exit", 32'(LPMC_RUN), 32'(pm_state));
		chk("idle_exit_cpu", 1, clk_en.cpu);
		// Sleep, interrupt wake, lock wait
		bus(1'b1, 1'b1, `LPMC_ADDR_PMC, 32'h000000F9);
		slp;
		chk("sleep_state", 32'(LPMC_SLEEP), 32'(pm_state));
		chk("sleep_en", 0, {clk_en.cpu, clk_en.basic, clk_en.pll, clk_en.module_en});
		irq_active = 1'b1;
		step;
		irq_active = 1'b0;
		chk("lock_state", 32'(LPMC_LOCK), 32'(pm_state));
		chk("lock_pll", 1, clk_en.pll);
		n = 0;
		while (pm_state !== LPMC_RUN && n < 300)
		begin
			chk("lock_basic", 0, clk_en.basic);
			n++;
			step;
		end
		// Three RTC edges seven clocks apart cannot pass in under 14 cycles
		chk("lock_wait_ends", 1, n < 300 && n >= 14);
		chk("run_en", 32'h0007FFFF, 32'(clk_en));
		// Mid-run reset while dozing and gated ends both
		bus(1'b1, 1'b1, `LPMC_ADDR_PMC, 32'h00000024);
		bus(1'b1, 1'b1, `LPMC_ADDR_GATE, 32'h0000FFFF);
		sys_rst = 1'b1;
		repeat (2) step;
		sys_rst = 1'b0;
		chk("reset_cpu", 1, clk_en.cpu);
		chk("reset_module_en", 32'h0000FFFF, 32'(clk_en.module_en));
		rd(`LPMC_ADDR_PMC, 32'h000000F8);
		step;
		chk("reads_done", 0, exp_q.size());
		print_verdict;
	end
endmodule // lpmc_top_tb
